// file: tcc_pin_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Far-side pin model
// ------------------------------------------------------------
module tcc_pin_model (
  // Clock
  input  wire logic       core_clk,
  // Pin levels: reload, t2, gate1, gate0, count1, count0
  output logic      [5:0] pinLvl
);
  // Count pins idle high like pulled-up port lines; gates closed
  initial begin
    pinLvl = 6'h33;
  end

  // slow pin events
  // Each level held at least 24 clocks so no edge is lost to the sampler
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge core_clk) pinLvl[idx] <= 1'b0;
      repeat (24) @(posedge core_clk);
      pinLvl[idx] <= 1'b1;
      repeat (24) @(posedge core_clk);
    end
  endtask
endmodule

// file: tcc_pkg.sv
package tcc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // Oscillator periods per machine cycle (core_clk stands for the oscillator)
  localparam int          MC_DIV      = 12;
  localparam logic [3:0]  MC_DIV_LAST = 4'(MC_DIV - 1);

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_TMR_CTRL        = 8'h88;
  localparam logic [7:0] REG_TMR_MODE        = 8'h89;
  localparam logic [7:0] REG_TMR0_LO         = 8'h8A;
  localparam logic [7:0] REG_TMR1_LO         = 8'h8B;
  localparam logic [7:0] REG_TMR0_HI         = 8'h8C;
  localparam logic [7:0] REG_TMR1_HI         = 8'h8D;
  localparam logic [7:0] REG_CAPCMP_ENABLE   = 8'hC1;
  localparam logic [7:0] REG_CAPCMP1_LO      = 8'hC2;
  localparam logic [7:0] REG_CAPCMP1_HI      = 8'hC3;
  localparam logic [7:0] REG_CAPCMP2_LO      = 8'hC4;
  localparam logic [7:0] REG_CAPCMP2_HI      = 8'hC5;
  localparam logic [7:0] REG_CAPCMP3_LO      = 8'hC6;
  localparam logic [7:0] REG_CAPCMP3_HI      = 8'hC7;
  localparam logic [7:0] REG_TIMER_TWO_CTRL  = 8'hC8;
  localparam logic [7:0] REG_RELOAD_CMP_LOW  = 8'hCA;
  localparam logic [7:0] REG_RELOAD_CMP_HIGH = 8'hCB;
  localparam logic [7:0] REG_TIMER_TWO_LOW   = 8'hCC;
  localparam logic [7:0] REG_TIMER_TWO_HIGH  = 8'hCD;
  localparam logic [7:0] REG_IRQ_STATUS      = 8'hE1;
  localparam logic [7:0] REG_IRQ_CLEAR       = 8'hE2;
  localparam logic [7:0] REG_IRQ_ENABLE      = 8'hE3;
  localparam logic [7:0] REG_CMP_LEVEL       = 8'hE4;

  // Common reset value of every register
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TCTL_RUN0  = 0;
  localparam int TCTL_RUN1  = 1;
  localparam int TMOD_M0    = 0;
  localparam int TMOD_CT0   = 2;
  localparam int TMOD_GATE0 = 3;
  localparam int TMOD_M1    = 4;
  localparam int TMOD_CT1   = 6;
  localparam int TMOD_GATE1 = 7;
  localparam int T2C_SRC    = 0;
  localparam int T2C_PRE    = 2;
  localparam int T2C_RLD_EN = 3;
  localparam int T2C_RLD_EXT = 4;
  localparam int T2C_CMP_M1 = 5;
  localparam int ST_OVF0    = 0;
  localparam int ST_OVF1    = 1;
  localparam int ST_OVF2    = 2;
  localparam int ST_RLD     = 3;
  localparam int ST_CC      = 4;

  // Synchronised pin vector positions
  localparam int PIN_CNT0  = 0;
  localparam int PIN_CNT1  = 1;
  localparam int PIN_GATE0 = 2;
  localparam int PIN_GATE1 = 3;
  localparam int PIN_T2    = 4;
  localparam int PIN_RLD   = 5;
  localparam int PIN_CC    = 6;
  localparam int PIN_NUM   = 10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCC_M13    = 2'h0,
    TCC_M16    = 2'h1,
    TCC_M8R    = 2'h2,
    TCC_MSPLIT = 2'h3
  } tcc_mode_e;

  typedef enum logic [1:0] {
    CC_OFF     = 2'h0,
    CC_CAP_PIN = 2'h1,
    CC_CMP     = 2'h2,
    CC_CAP_SW  = 2'h3
  } tcc_ccmode_e;

  typedef enum logic [1:0] {
    T2_STOP  = 2'h0,
    T2_TIMER = 2'h1,
    T2_COUNT = 2'h2,
    T2_GATED = 2'h3
  } tcc_t2src_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcc_bus_s;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ovf;
  } tcc_cnt_s;

endpackage

// file: tcc_timer_top.sv
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/100ps
// Function
// - Timer operation counts one per twelve oscillator periods.
// - Counter operation counts pin edges, at most one per 24 periods.
// - Mode 0 is an 8-bit counter behind a divide-by-32 prescaler.
// - Mode 1 runs the timer as a full 16-bit counter.
// - Mode 2 is an 8-bit counter reloaded from the high byte on overflow.
// - Mode 3 splits timer zero in two; timer one holds its count.
// - With gating set, timers zero and one count only while gate pin high, except the split-mode upper half of timer zero.
// - Third timer is 16 bits with optional divide-by-two and gate.
// - Four 16-bit capture/compare registers; channel zero is also reload value.
// - Reload mode zero loads the third timer on its overflow.
// - Reload mode one loads on a reload pin falling edge and flags it.
// - Capture mode zero latches the third timer on a capture pin edge.
// - Capture mode one latches the third timer on a low-byte write.
// - Compare mode drives an output and flags a request on equality.
// - Compare mode zero sets output on match, clears on overflow.
// - Compare mode one sets software-chosen level; overflow leaves it.
// - A dedicated pin is count source or gate of the third timer.
// - Separate pins are count inputs of timers zero and one.
module tcc_timer_top
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Register port
  input  wire tcc_bus_s   busReq,
  output logic [7:0]      rdData,
  // Timer pins
  input  wire logic       countInZero,
  input  wire logic       countInOne,
  input  wire logic       extIrqZeroGate,
  input  wire logic       extIrqOneGate,
  input  wire logic       countGateInTwo,
  input  wire logic       reloadTriggerPin,
  // Capture/compare pins
  input  wire logic [3:0] capCmpPinIn,
  output logic [3:0]      capCmpPinOut,
  output logic [3:0]      capCmpPinOe,
  // Interrupt
  output logic            irq
);

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  // Step of an 8-bit-wide timer pair in modes 0 to 3
  function automatic tcc_cnt_s tccCount(input tcc_mode_e m, input logic [7:0] lo,
                                        input logic [7:0] hi, input logic inc);
    tcc_cnt_s r;
    r.lo  = lo;
    r.hi  = hi;
    r.ovf = 1'b0;
    if (inc) begin
      case (m)
        TCC_M13: begin
          {r.hi, r.lo[4:0]} = 13'({hi, lo[4:0]} + 13'h0001);
          r.ovf = &{hi, lo[4:0]};
        end
        TCC_M16: begin
          {r.hi, r.lo} = 16'({hi, lo} + 16'h0001);
          r.ovf = &{hi, lo};
        end
        TCC_M8R: begin
          r.lo  = (&lo) ? hi : 8'(lo + 8'h01);
          r.ovf = &lo;
        end
        default: begin
          r.lo  = 8'(lo + 8'h01);
          r.ovf = &lo;
        end
      endcase
    end
    return r;
  endfunction

  // Capture/compare byte decode: {hit, high byte, channel}
  function automatic logic [3:0] tccChan(input logic [7:0] a);
    case (a)
      REG_RELOAD_CMP_LOW:  return {1'b1, 1'b0, 2'h0};
      REG_RELOAD_CMP_HIGH: return {1'b1, 1'b1, 2'h0};
      REG_CAPCMP1_LO:      return {1'b1, 1'b0, 2'h1};
      REG_CAPCMP1_HI:      return {1'b1, 1'b1, 2'h1};
      REG_CAPCMP2_LO:      return {1'b1, 1'b0, 2'h2};
      REG_CAPCMP2_HI:      return {1'b1, 1'b1, 2'h2};
      REG_CAPCMP3_LO:      return {1'b1, 1'b0, 2'h3};
      REG_CAPCMP3_HI:      return {1'b1, 1'b1, 2'h3};
      default:             return 4'h0;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Machine cycle divider and pin sampling
  // ------------------------------------------------------------------
  logic [3:0]         mcDiv_r;
  logic               mcEn;
  logic [PIN_NUM-1:0] pinRaw;
  logic [PIN_NUM-1:0] sync1_r;
  logic [PIN_NUM-1:0] sync2_r;
  logic [PIN_NUM-1:0] smp_r;
  logic [PIN_NUM-1:0] pinFall;
  logic [PIN_NUM-1:0] pinRise;

  assign mcEn = (mcDiv_r == MC_DIV_LAST);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mcDiv_r <= 4'h0;
    end else begin
      mcDiv_r <= mcEn ? 4'h0 : 4'(mcDiv_r + 4'h1);
    end
  end

  assign pinRaw = {capCmpPinIn, reloadTriggerPin, countGateInTwo, extIrqOneGate,
                   extIrqZeroGate, countInOne, countInZero};

  // Two-stage synchroniser, then one sample per machine cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      smp_r   <= '0;
    end else begin
      sync1_r <= pinRaw;
      sync2_r <= sync1_r;
      if (mcEn) begin
        smp_r <= sync2_r;
      end
    end
  end

  // falling edge needs high then low sample, rising edge low then high, so 24 periods apart at least
  assign pinFall = {PIN_NUM{mcEn}} & smp_r & ~sync2_r;
  assign pinRise = {PIN_NUM{mcEn}} & ~smp_r & sync2_r;

  // ------------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------------
  logic [7:0] tctl_r;
  logic [7:0] tmod_r;
  logic [7:0] t2con_r;
  logic [7:0] ccen_r;
  logic [7:0] ien_r;
  logic [3:0] cmpLvl_r;
  logic [3:0] chDec;
  logic       wrT0Lo, wrT0Hi, wrT1Lo, wrT1Hi, wrT2Lo, wrT2Hi, wrClr;

  assign chDec  = tccChan(busReq.addr);
  assign wrT0Lo = busReq.wr && (busReq.addr == REG_TMR0_LO);
  assign wrT0Hi = busReq.wr && (busReq.addr == REG_TMR0_HI);
  assign wrT1Lo = busReq.wr && (busReq.addr == REG_TMR1_LO);
  assign wrT1Hi = busReq.wr && (busReq.addr == REG_TMR1_HI);
  assign wrT2Lo = busReq.wr && (busReq.addr == REG_TIMER_TWO_LOW);
  assign wrT2Hi = busReq.wr && (busReq.addr == REG_TIMER_TWO_HIGH);
  assign wrClr  = busReq.wr && (busReq.addr == REG_IRQ_CLEAR);

  // Plain control registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tctl_r   <= RST_BYTE;
      tmod_r   <= RST_BYTE;
      t2con_r  <= RST_BYTE;
      ccen_r   <= RST_BYTE;
      ien_r    <= RST_BYTE;
      cmpLvl_r <= RST_BYTE[3:0];
    end else if (busReq.wr) begin
      case (busReq.addr)
        REG_TMR_CTRL:       tctl_r   <= busReq.wdata;
        REG_TMR_MODE:       tmod_r   <= busReq.wdata;
        REG_TIMER_TWO_CTRL: t2con_r  <= busReq.wdata;
        REG_CAPCMP_ENABLE:  ccen_r   <= busReq.wdata;
        REG_IRQ_ENABLE:     ien_r    <= busReq.wdata;
        REG_CMP_LEVEL:      cmpLvl_r <= busReq.wdata[3:0];
        default:            ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Timers zero and one
  // ------------------------------------------------------------------
  logic [7:0] tmr0Lo_r, tmr0Hi_r, tmr1Lo_r, tmr1Hi_r;
  tcc_mode_e  mode0, mode1;
  logic       tick0, tick1, splitHiTick, splitHiOvf;
  tcc_cnt_s   cnt0, cnt1;
  logic [7:0] tmr0HiNxt;

  assign mode0 = tcc_mode_e'(tmod_r[TMOD_M0 +: 2]);
  assign mode1 = tcc_mode_e'(tmod_r[TMOD_M1 +: 2]);

  assign tick0 = tctl_r[TCTL_RUN0]
               & (~tmod_r[TMOD_GATE0] | sync2_r[PIN_GATE0])
               & (tmod_r[TMOD_CT0] ? pinFall[PIN_CNT0] : mcEn);
  // timer one frozen in split mode
  assign tick1 = tctl_r[TCTL_RUN1] & (mode1 != TCC_MSPLIT)
               & (~tmod_r[TMOD_GATE1] | sync2_r[PIN_GATE1])
               & (tmod_r[TMOD_CT1] ? pinFall[PIN_CNT1] : mcEn);

  assign cnt0 = tccCount(mode0, tmr0Lo_r, tmr0Hi_r, tick0);
  assign cnt1 = tccCount(mode1, tmr1Lo_r, tmr1Hi_r, tick1);

  // upper half of timer zero as own timer, run by timer one's run bit
  assign splitHiTick = (mode0 == TCC_MSPLIT) & tctl_r[TCTL_RUN1] & mcEn;
  assign splitHiOvf  = splitHiTick & (&tmr0Hi_r);
  assign tmr0HiNxt   = (mode0 != TCC_MSPLIT) ? cnt0.hi :
                       splitHiTick ? 8'(tmr0Hi_r + 8'h01) : tmr0Hi_r;

  // Software writes take precedence over a count in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tmr0Lo_r <= RST_BYTE;
      tmr0Hi_r <= RST_BYTE;
      tmr1Lo_r <= RST_BYTE;
      tmr1Hi_r <= RST_BYTE;
    end else begin
      tmr0Lo_r <= wrT0Lo ? busReq.wdata : cnt0.lo;
      tmr0Hi_r <= wrT0Hi ? busReq.wdata : tmr0HiNxt;
      tmr1Lo_r <= wrT1Lo ? busReq.wdata : cnt1.lo;
      tmr1Hi_r <= wrT1Hi ? busReq.wdata : cnt1.hi;
    end
  end

  // ------------------------------------------------------------------
  // Third timer with reload
  // ------------------------------------------------------------------
  logic [15:0] t2_r;
  logic [15:0] t2Nxt;
  logic [15:0] cc_r [4];
  logic        pre_r;
  tcc_t2src_e  t2Src;
  logic        t2Raw, tick2, t2Ovf, reloadExt, reloadOvf;

  assign t2Src = tcc_t2src_e'(t2con_r[T2C_SRC +: 2]);

  // source select on the dedicated pin
  assign t2Raw = (t2Src == T2_TIMER) ? mcEn :
                 (t2Src == T2_COUNT) ? pinFall[PIN_T2] :
                 (t2Src == T2_GATED) ? (mcEn & sync2_r[PIN_T2]) : 1'b0;
  assign tick2 = t2Raw & (~t2con_r[T2C_PRE] | pre_r);
  assign t2Ovf = tick2 & (&t2_r);

  assign reloadOvf = t2Ovf & t2con_r[T2C_RLD_EN] & ~t2con_r[T2C_RLD_EXT];
  assign reloadExt = pinFall[PIN_RLD] & t2con_r[T2C_RLD_EN] & t2con_r[T2C_RLD_EXT];

  // channel zero doubles as reload value
  assign t2Nxt = (reloadOvf | reloadExt) ? cc_r[0] :
                 tick2 ? 16'(t2_r + 16'h0001) : t2_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      t2_r  <= {RST_BYTE, RST_BYTE};
      pre_r <= 1'b0;
    end else begin
      t2_r[7:0]  <= wrT2Lo ? busReq.wdata : t2Nxt[7:0];
      t2_r[15:8] <= wrT2Hi ? busReq.wdata : t2Nxt[15:8];
      if (t2Raw & t2con_r[T2C_PRE]) begin
        pre_r <= ~pre_r;
      end
    end
  end

  // ------------------------------------------------------------------
  // Capture/compare channels
  // ------------------------------------------------------------------
  tcc_ccmode_e ccMode [4];
  logic [3:0]  capEvt, swCap, eq, match;
  logic [3:0]  eqPrev_r;
  logic [3:0]  cmpOut_r;
  logic [3:0]  cmpOe_r;
  logic        cmpMode1;

  assign cmpMode1 = t2con_r[T2C_CMP_M1];

  for (genvar i = 0; i < 4; i++) begin : gChan
    assign ccMode[i] = tcc_ccmode_e'(ccen_r[2*i +: 2]);
    assign capEvt[i] = (ccMode[i] == CC_CAP_PIN) & pinRise[PIN_CC + i];
    assign swCap[i]  = (ccMode[i] == CC_CAP_SW) & chDec[3] & ~chDec[2]
                     & (chDec[1:0] == 2'(i)) & busReq.wr;
    // equality, one event per new match
    assign eq[i]     = (ccMode[i] == CC_CMP) & (t2_r == cc_r[i]);
    assign match[i]  = eq[i] & ~eqPrev_r[i];
  end

  // Channel storage; a capture wins over a plain byte write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        cc_r[i] <= {RST_BYTE, RST_BYTE};
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (capEvt[i] | swCap[i]) begin
          cc_r[i] <= t2_r;
        end else if (busReq.wr && chDec[3] && (chDec[1:0] == 2'(i))) begin
          if (chDec[2]) begin
            cc_r[i][15:8] <= busReq.wdata;
          end else begin
            cc_r[i][7:0] <= busReq.wdata;
          end
        end
      end
    end
  end

  // Compare outputs; pin is driven only while its channel compares
  always_ff @(posedge core_clk) begin
    if (rst) begin
      eqPrev_r <= 4'h0;
      cmpOut_r <= 4'h0;
      cmpOe_r  <= 4'h0;
    end else begin
      eqPrev_r <= eq;
      for (int i = 0; i < 4; i++) begin
        cmpOe_r[i] <= (ccMode[i] == CC_CMP);
        // match level, overflow clear in mode zero only
        if (match[i]) begin
          cmpOut_r[i] <= cmpMode1 ? cmpLvl_r[i] : 1'b1;
        end else if (t2Ovf && !cmpMode1) begin
          cmpOut_r[i] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Interrupt status and read back
  // ------------------------------------------------------------------
  logic [7:0] status_r;
  logic [7:0] statSet;
  logic [7:0] statNxt;
  logic       irq_r;
  logic [7:0] rdMux;
  logic [7:0] rdData_r;

  // overflow flags; edge and match requests
  assign statSet = {(capEvt | match), reloadExt, t2Ovf, (cnt1.ovf | splitHiOvf), cnt0.ovf};
  // A new event wins over a clear in the same cycle
  assign statNxt = (status_r & ~(wrClr ? busReq.wdata : 8'h00)) | statSet;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_r <= RST_BYTE;
      irq_r    <= 1'b0;
      rdData_r <= RST_BYTE;
    end else begin
      status_r <= statNxt;
      irq_r    <= |(statNxt & ien_r);
      rdData_r <= busReq.rd ? rdMux : 8'h00;
    end
  end

  // Read selection; unmapped and write-only offsets read zero
  always_comb begin
    rdMux = 8'h00;
    if (chDec[3]) begin
      rdMux = chDec[2] ? cc_r[chDec[1:0]][15:8] : cc_r[chDec[1:0]][7:0];
    end else begin
      case (busReq.addr)
        REG_TMR_CTRL:       rdMux = tctl_r;
        REG_TMR_MODE:       rdMux = tmod_r;
        REG_TMR0_LO:        rdMux = tmr0Lo_r;
        REG_TMR0_HI:        rdMux = tmr0Hi_r;
        REG_TMR1_LO:        rdMux = tmr1Lo_r;
        REG_TMR1_HI:        rdMux = tmr1Hi_r;
        REG_CAPCMP_ENABLE:  rdMux = ccen_r;
        REG_TIMER_TWO_CTRL: rdMux = t2con_r;
        REG_TIMER_TWO_LOW:  rdMux = t2_r[7:0];
        REG_TIMER_TWO_HIGH: rdMux = t2_r[15:8];
        REG_IRQ_STATUS:     rdMux = status_r;
        REG_IRQ_ENABLE:     rdMux = ien_r;
        REG_CMP_LEVEL:      rdMux = {4'h0, cmpLvl_r};
        default:            rdMux = 8'h00;
      endcase
    end
  end

  assign rdData       = rdData_r;
  assign irq          = irq_r;
  assign capCmpPinOut = cmpOut_r;
  assign capCmpPinOe  = cmpOe_r;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cbAst @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_MC_PERIOD: assert property (
    mcEn |=> (!mcEn)[*8] ##1 (!mcEn)[*3] ##1 mcEn)
    else $error("machine cycle tick not every 12 clocks");

  AST_EXT_RATE: assert property (
    pinFall[PIN_CNT1] |=> (!pinFall[PIN_CNT1])[*8] ##1 (!pinFall[PIN_CNT1])[*8]
                          ##1 (!pinFall[PIN_CNT1])[*7])
    else $error("count edges closer than 24 clocks");

  AST_M0_PRESCALE: assert property (
    (mode0 == TCC_M13) && tick0 && (tmr0Lo_r[4:0] != 5'h1F) && !wrT0Hi
      |=> tmr0Hi_r == $past(tmr0Hi_r))
    else $error("mode 0 high byte moved before prescaler wrapped");

  AST_M1_WRAP: assert property (
    (mode0 == TCC_M16) && tick0 && ({tmr0Hi_r, tmr0Lo_r} == 16'hFFFF) && !wrT0Lo && !wrT0Hi
      |=> ({tmr0Hi_r, tmr0Lo_r} == 16'h0000) && status_r[ST_OVF0])
    else $error("mode 1 rollover wrong");

  AST_M2_RELOAD: assert property (
    (mode0 == TCC_M8R) && tick0 && (tmr0Lo_r == 8'hFF) && !wrT0Lo
      |=> tmr0Lo_r == $past(tmr0Hi_r))
    else $error("mode 2 reload value wrong");

  AST_M3_HOLD: assert property (
    (mode1 == TCC_MSPLIT) && !wrT1Lo && !wrT1Hi |=> $stable(tmr1Lo_r) && $stable(tmr1Hi_r))
    else $error("timer one moved in split mode");

  AST_GATE: assert property (
    tmod_r[TMOD_GATE0] && !sync2_r[PIN_GATE0] && !wrT0Lo |=> $stable(tmr0Lo_r))
    else $error("timer zero counted with gate closed");

  AST_T2_RELOAD: assert property (
    reloadOvf && !wrT2Lo && !wrT2Hi |=> t2_r == $past(cc_r[0]))
    else $error("third timer overflow reload wrong");

  AST_SW_CAPTURE: assert property (
    swCap[3] |=> cc_r[3] == $past(t2_r))
    else $error("software capture did not latch timer");

  AST_CMP_RISE: assert property (
    match[2] && !cmpMode1 |=> capCmpPinOut[2] ##1 (capCmpPinOut[2] || $past(t2Ovf)))
    else $error("compare output not set on match");

  AST_TF_IRQ: assert property (
    cnt0.ovf && ien_r[ST_OVF0] |=> status_r[ST_OVF0] && irq)
    else $error("overflow flag or interrupt missing");

endmodule

// file: tcc_timer_top_tb_top.sv
`timescale 1ns/100ps
module tcc_timer_top_tb_top;
  import tcc_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic       core_clk;
  logic       rst;
  tcc_bus_s   bus;
  logic [7:0] rdData;
  logic [5:0] pins;
  logic [3:0] capIn;
  logic [3:0] capOut;
  logic [3:0] capOe;
  logic       irq;
  logic [7:0] v;
  int         n_errors;
  int         n_tests;

  // Design and far side
  tcc_timer_top DUT (
    .core_clk(core_clk), .rst(rst), .busReq(bus), .rdData(rdData),
    .countInZero(pins[0]), .countInOne(pins[1]), .extIrqZeroGate(pins[2]),
    .extIrqOneGate(pins[3]), .countGateInTwo(pins[4]), .reloadTriggerPin(pins[5]),
    .capCmpPinIn(capIn), .capCmpPinOut(capOut), .capCmpPinOe(capOe), .irq(irq)
  );
  tcc_pin_model PM (.core_clk(core_clk), .pinLvl(pins));

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // Bus tasks and compare
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk) bus.rd <= 1'b0;
    #1 d = rdData;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  task automatic summarize;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Whole run needs about 1300 clocks
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    summarize;
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    bus = '0;
    capIn = 4'hF;
    n_errors = 0;
    n_tests = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rc(REG_TMR_MODE, RST_BYTE);
    rc(8'h90, 8'h00);
    // Timer zero free running, about 243 clocks
    wr(REG_TMR_MODE, 8'h01);
    wr(REG_TMR_CTRL, 8'h01);
    repeat (240) @(posedge core_clk);
    wr(REG_TMR_CTRL, 8'h00);
    rd(REG_TMR0_LO, v);
    chk(8'(v inside {[8'd19:8'd21]}), 8'h01);
    // Full 16-bit rollover, flag, mask and clear
    wr(REG_TMR0_LO, 8'hFE);
    wr(REG_TMR0_HI, 8'hFF);
    wr(REG_IRQ_ENABLE, 8'h01);
    wr(REG_TMR_CTRL, 8'h01);
    repeat (30) @(posedge core_clk);
    wr(REG_TMR_CTRL, 8'h00);
    rc(REG_TMR0_HI, 8'h00);
    rc(REG_IRQ_STATUS, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr(REG_IRQ_ENABLE, 8'h00);
    rc(REG_IRQ_STATUS, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wr(REG_IRQ_CLEAR, 8'h01);
    rc(REG_IRQ_STATUS, 8'h00);
    // Timer one counts pin events, timer zero gated shut
    wr(REG_TMR0_LO, 8'h00);
    wr(REG_TMR_MODE, 8'h59);
    wr(REG_TMR_CTRL, 8'h03);
    PM.pulse(1, 3);
    repeat (30) @(posedge core_clk);
    wr(REG_TMR_CTRL, 8'h00);
    rc(REG_TMR1_LO, 8'h03);
    rc(REG_TMR0_LO, 8'h00);
    // Third timer: compare ch2, pin capture ch1, pin reload
    wr(REG_CAPCMP2_LO, 8'h05);
    wr(REG_CAPCMP_ENABLE, 8'h24);
    wr(REG_RELOAD_CMP_HIGH, 8'h12);
    wr(REG_TIMER_TWO_CTRL, 8'h19);
    repeat (80) @(posedge core_clk);
    chk({6'h0, capOe[2], capOut[2]}, 8'h03);
    rc(REG_IRQ_STATUS, 8'h40);
    capIn[1] <= 1'b0;
    repeat (24) @(posedge core_clk);
    capIn[1] <= 1'b1;
    repeat (24) @(posedge core_clk);
    rc(REG_IRQ_STATUS, 8'h60);
    rd(REG_CAPCMP1_LO, v);
    chk(8'(v != 8'h00), 8'h01);
    PM.pulse(5, 1);
    rc(REG_TIMER_TWO_HIGH, 8'h12);
    rc(REG_IRQ_STATUS, 8'h68);
    // Software capture on ch3, then third timer counting its pin
    wr(REG_CAPCMP_ENABLE, 8'hC0);
    wr(REG_CAPCMP3_LO, 8'h00);
    rc(REG_CAPCMP3_HI, 8'h12);
    wr(REG_TIMER_TWO_CTRL, 8'h02);
    wr(REG_TIMER_TWO_LOW, 8'h00);
    wr(REG_TIMER_TWO_HIGH, 8'h00);
    PM.pulse(4, 4);
    rc(REG_TIMER_TWO_LOW, 8'h04);
    wr(REG_TIMER_TWO_CTRL, 8'h06);
    PM.pulse(4, 4);
    rc(REG_TIMER_TWO_LOW, 8'h06);
    // Overflow reload; compare mode one keeps its level over overflow
    wr(REG_TIMER_TWO_HIGH, 8'hFF);
    wr(REG_TIMER_TWO_LOW, 8'hFD);
    wr(REG_CAPCMP2_HI, 8'hFF);
    wr(REG_CAPCMP2_LO, 8'hFE);
    wr(REG_CAPCMP_ENABLE, 8'h20);
    wr(REG_CMP_LEVEL, 8'h04);
    wr(REG_IRQ_CLEAR, 8'hFF);
    wr(REG_TIMER_TWO_CTRL, 8'h29);
    repeat (60) @(posedge core_clk);
    chk({7'h0, capOut[2]}, 8'h01);
    rc(REG_TIMER_TWO_HIGH, 8'h12);
    rc(REG_IRQ_STATUS, 8'h44);
    // Timer zero prescaled, auto-reload and split modes
    wr(REG_TMR_MODE, 8'h00);
    wr(REG_TMR0_LO, 8'h1E);
    wr(REG_TMR0_HI, 8'h00);
    wr(REG_TMR_CTRL, 8'h01);
    repeat (30) @(posedge core_clk);
    wr(REG_TMR_CTRL, 8'h00);
    rc(REG_TMR0_HI, 8'h01);
    wr(REG_TMR_MODE, 8'h02);
    wr(REG_TMR0_HI, 8'h80);
    wr(REG_TMR0_LO, 8'hFE);
    wr(REG_TMR_CTRL, 8'h01);
    repeat (30) @(posedge core_clk);
    wr(REG_TMR_CTRL, 8'h00);
    rd(REG_TMR0_LO, v);
    chk(8'(v inside {[8'h80:8'h81]}), 8'h01);
    wr(REG_TMR_MODE, 8'h33);
    wr(REG_TMR_CTRL, 8'h03);
    repeat (30) @(posedge core_clk);
    wr(REG_TMR_CTRL, 8'h00);
    rc(REG_TMR1_LO, 8'h03);
    rd(REG_TMR0_HI, v);
    chk(8'(v inside {[8'h82:8'h83]}), 8'h01);
    summarize;
  end
endmodule
